// ---- rtl/bsta_pkg.sv ----
package bsta_pkg;

    localparam logic [11:0] WINDOW_SPAN    = 12'hfff;
    localparam logic [11:0] MODE_SEL_OFS   = 12'h000;
    localparam int          LOC_LOW_BIT    = 2;
    localparam int          LOC_HIGH_BIT   = 10;
    localparam int          LOC_COUNT      = 9;
    localparam int          LOC_WRITES     = 3;

    // location index = address bit - LOC_LOW_BIT
    localparam int LOC_COPROC_IN   = 8;
    localparam int LOC_INPUT_VEC   = 7;
    localparam int LOC_DATA_IN     = 6;
    localparam int LOC_DATA_OUT    = 5;
    localparam int LOC_COPROC_OUT  = 4;
    localparam int LOC_COPROC_INST = 3;
    localparam int LOC_STATUS1     = 2;
    localparam int LOC_STATUS2     = 1;
    localparam int LOC_ADDR_OUT    = 0;

    localparam logic [31:0] CODE_EXIT     = 32'h0000_0000;
    localparam logic [31:0] CODE_FUNC     = 32'h0000_0001;
    localparam logic [31:0] CODE_TAG      = 32'h0000_0002;
    localparam logic [31:0] CODE_ITRANS   = 32'h0000_0003;
    localparam logic [31:0] CODE_DTRANS   = 32'h0000_0004;
    localparam logic [31:0] CODE_ICACHE   = 32'h0000_0005;
    localparam logic [31:0] CODE_DCACHE   = 32'h0000_0006;

    localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
    localparam logic [8:0]  RESET_PEND    = 9'h000;
    localparam int          STATUS1_WIDTH = 22;

    typedef enum logic [6:0] {
        MODE_EXIT   = 7'b000_0001,
        MODE_FUNC   = 7'b000_0010,
        MODE_TAG    = 7'b000_0100,
        MODE_ITRANS = 7'b000_1000,
        MODE_DTRANS = 7'b001_0000,
        MODE_ICACHE = 7'b010_0000,
        MODE_DCACHE = 7'b100_0000
    } bsta_mode_type;

    typedef struct packed {
        logic       bus_grant;
        logic       wait_in_a;
        logic       error_in_b;
        logic       last_in_c;
        logic       bus_reset_n;
        logic       fast_clock;
        logic [5:0] zero_pad;
        logic       high_vector_select;
        logic       fast_irq_n;
        logic       irq_n;
        logic       input_sync_select;
        logic [1:0] coproc_handshake_decode;
        logic [1:0] coproc_handshake_execute;
        logic       tracking_enable;
        logic       instr_breakpoint;
        logic       data_watchpoint;
        logic       external_debug_request;
        logic       external_watch0;
        logic       external_watch1;
        logic       tck;
        logic       tdi;
        logic       tms;
        logic       trst_n;
        logic       scan_return_data;
        logic       debug_enable;
    } bsta_core_in_type;

    typedef struct packed {
        logic       write_out;
        logic [1:0] size;
        logic [1:0] prot;
        logic [1:0] burst;
        logic       bus_request;
        logic       lock;
        logic       transfer_type;
        logic       addr_drive_en;
        logic       data_drive_en;
        logic       fast_clock_out;
        logic       coproc_clock;
        logic [4:0] coproc_handshake_out;
        logic       coproc_translate_n;
        logic       endianness_out;
        logic       instr_executed;
    } bsta_status1_type;

    typedef struct packed {
        logic       scan_drive_out;
        logic       debug_ack;
        logic       emu_clock;
        logic [3:0] instr_reg;
        logic       range_out0;
        logic       range_out1;
        logic [4:0] scan_reg_select;
        logic [3:0] tap_state;
        logic       tdo;
        logic       tdo_enable_n;
        logic       scan_data_in;
        logic       shift_clock1;
        logic       shift_clock2;
        logic       icapture_clock;
        logic       ecapture_clock;
        logic       pclock;
        logic       tck1;
        logic       tck2;
        logic       reset_clock;
        logic       comm_rx;
        logic       comm_tx;
        logic       debug_request_int;
    } bsta_status2_type;

    typedef struct packed {
        logic [31:0]      data_out;
        logic [31:0]      coproc_output_data;
        logic [31:0]      coproc_instruction;
        bsta_status1_type status1;
        bsta_status2_type status2;
        logic [31:0]      address_output;
    } bsta_core_out_type;

endpackage : bsta_pkg

// ---- rtl/bsta_isolate.sv ----
`timescale 1ns/1ps
module bsta_isolate (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      isolate,
    input  wire bsta_pkg::bsta_core_in_type pin_inputs,
    input  wire bsta_pkg::bsta_core_in_type test_inputs,
    output bsta_pkg::bsta_core_in_type      core_inputs,
    output logic                           pin_drivers_en
);

    // flopped so the core never sees a glitch while the source swaps
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            core_inputs    <= bsta_pkg::bsta_core_in_type'(bsta_pkg::RESET_WORD);
            pin_drivers_en <= 1'b1;
        end else begin
            core_inputs    <= isolate ? test_inputs : pin_inputs;
            pin_drivers_en <= !isolate;
        end
    end

endmodule : bsta_isolate

// ---- rtl/bsta_slave.sv ----
`timescale 1ns/1ps
// Contract
// - slave answers word-aligned accesses in the window base to base plus 0xfff.
// - mode-select at offset 0x0; a write of a defined code there switches the test mode, other codes leave it.
// - mode codes 0 exit, 1 functional, 2 tag, 3/4 translation, 5/6 cache.
// - functional mode isolates core from pins and disables its output drivers.
// - functional mode exposes nine locations: three writes, six reads.
// - address bits 10 down to 2 each select one functional location.
// - id register and trace outputs are unreachable through any location.
// - input vector bits 31 to 16 drive bus, clock, interrupt, sync inputs.
// - input vector bits 15 to 0 drive handshake, debug and scan inputs.
// - first status bits 21 to 3 return bus and coprocessor outputs.
// - first status bits 2,1,0 return translate, endianness, executed flag.
// - core steps one clock after each write sequence; reads optional.
// - second status returns debug and scan chain state and comms flags.
module bsta_slave (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic                        bus_sel,
    input  wire logic                        bus_write,
    input  wire logic [31:0]                 slave_address_in,
    input  wire logic [31:0]                 bus_wdata,
    output logic [31:0]                      bus_rdata,
    output logic                             bus_rvalid,
    input  wire bsta_pkg::bsta_core_in_type  pin_inputs,
    input  wire bsta_pkg::bsta_core_out_type core_outputs,
    output bsta_pkg::bsta_core_in_type       core_inputs,
    output logic                             pin_drivers_en,
    output logic [31:0]                      core_data_in,
    output logic [31:0]                      core_coproc_data_in,
    output logic                             core_step,
    output bsta_pkg::bsta_mode_type          test_mode
);

    logic                       in_window;
    logic                       mode_hit;
    logic                       func_hit;
    logic [8:0]                 addr_sel;
    logic [8:0]                 pend;
    logic [8:0]                 active_set;
    logic [8:0]                 serve_onehot;
    logic [8:0]                 next_pend;
    logic [3:0]                 serve_idx;
    logic                       serve_any;
    logic                       serve_write;
    logic                       wrote_since_step;
    logic [3:0]                 last_write_idx;
    logic                       seq_restart;
    logic                       next_step;
    bsta_pkg::bsta_core_in_type test_vector;
    bsta_pkg::bsta_mode_type    next_mode;
    logic [31:0]                next_rdata;

    // the decoder already qualified the base; only the low 12 bits matter
    assign in_window = bus_sel && (slave_address_in[1:0] == 2'b00);
    assign mode_hit  = in_window && (slave_address_in[11:0] == bsta_pkg::MODE_SEL_OFS);
    assign func_hit  = in_window && (test_mode == bsta_pkg::MODE_FUNC) && !mode_hit;
    assign addr_sel  = slave_address_in[bsta_pkg::LOC_HIGH_BIT:bsta_pkg::LOC_LOW_BIT];

    // several bits at once are worked off one per access, highest first
    assign active_set = (pend == bsta_pkg::RESET_PEND) ? addr_sel : pend;

    always_comb begin
        serve_onehot = 9'h000;
        serve_idx    = 4'h0;
        serve_any    = 1'b0;
        for (int i = 0; i < bsta_pkg::LOC_COUNT; i++) begin
            if (active_set[i]) begin
                serve_onehot = 9'h000;
                serve_onehot[i] = 1'b1;
                serve_idx    = 4'(i);
                serve_any    = 1'b1;
            end
        end
    end

    // top three locations accept writes, the lower six return reads
    assign serve_write = serve_any && (serve_idx >= 4'(bsta_pkg::LOC_COUNT - bsta_pkg::LOC_WRITES));
    assign next_pend   = active_set & ~serve_onehot;

    always_comb begin
        next_mode = test_mode;
        unique case (bus_wdata)
            bsta_pkg::CODE_EXIT:   next_mode = bsta_pkg::MODE_EXIT;
            bsta_pkg::CODE_FUNC:   next_mode = bsta_pkg::MODE_FUNC;
            bsta_pkg::CODE_TAG:    next_mode = bsta_pkg::MODE_TAG;
            bsta_pkg::CODE_ITRANS: next_mode = bsta_pkg::MODE_ITRANS;
            bsta_pkg::CODE_DTRANS: next_mode = bsta_pkg::MODE_DTRANS;
            bsta_pkg::CODE_ICACHE: next_mode = bsta_pkg::MODE_ICACHE;
            bsta_pkg::CODE_DCACHE: next_mode = bsta_pkg::MODE_DCACHE;
            default:               next_mode = test_mode; // undefined codes leave mode alone
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            test_mode <= bsta_pkg::MODE_EXIT;
        end else if (mode_hit && bus_write) begin
            test_mode <= next_mode;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend <= bsta_pkg::RESET_PEND;
        end else if (mode_hit && bus_write) begin
            pend <= bsta_pkg::RESET_PEND;
        end else if (func_hit && serve_any && (bus_write == serve_write)) begin
            pend <= next_pend;
        end
    end

    // a write to a location at or above the last one written opens a new vector
    assign seq_restart = wrote_since_step && (serve_idx >= last_write_idx);
    always_comb begin
        next_step = 1'b0;
        if (func_hit && serve_any && wrote_since_step) begin
            if (!bus_write || (bus_write && serve_write && seq_restart)) begin
                next_step = 1'b1;
            end
        end
        if (mode_hit && wrote_since_step) begin
            next_step = 1'b1; // last vector still gets its clock on leaving
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrote_since_step <= 1'b0;
            last_write_idx   <= 4'h0;
        end else if (func_hit && bus_write && serve_write) begin
            wrote_since_step <= 1'b1;
            last_write_idx   <= serve_idx;
        end else if (next_step) begin
            wrote_since_step <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            core_step <= 1'b0;
        end else begin
            core_step <= next_step;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            test_vector         <= bsta_pkg::bsta_core_in_type'(bsta_pkg::RESET_WORD);
            core_data_in        <= bsta_pkg::RESET_WORD;
            core_coproc_data_in <= bsta_pkg::RESET_WORD;
        end else if (func_hit && bus_write && serve_write) begin
            unique case (serve_idx)
                4'(bsta_pkg::LOC_COPROC_IN): core_coproc_data_in <= bus_wdata;
                4'(bsta_pkg::LOC_INPUT_VEC): begin
                    test_vector          <= bsta_pkg::bsta_core_in_type'(bus_wdata);
                    test_vector.zero_pad <= 6'h00;
                end
                default:                     core_data_in        <= bus_wdata;
            endcase
        end
    end

    // only the six output locations have a read path: id and trace stay hidden
    always_comb begin
        next_rdata = bsta_pkg::RESET_WORD;
        if (func_hit && !bus_write && serve_any && !serve_write) begin
            unique case (serve_idx)
                4'(bsta_pkg::LOC_DATA_OUT):    next_rdata = core_outputs.data_out;
                4'(bsta_pkg::LOC_COPROC_OUT):  next_rdata = core_outputs.coproc_output_data;
                4'(bsta_pkg::LOC_COPROC_INST): next_rdata = core_outputs.coproc_instruction;
                4'(bsta_pkg::LOC_STATUS1):     next_rdata = {10'h000, core_outputs.status1};
                4'(bsta_pkg::LOC_STATUS2):     next_rdata = core_outputs.status2;
                default:                       next_rdata = core_outputs.address_output;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_rdata  <= bsta_pkg::RESET_WORD;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rdata  <= next_rdata;
            bus_rvalid <= in_window && !bus_write; // unmapped reads answer zero
        end
    end

    bsta_isolate u_isolate (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .isolate        (test_mode == bsta_pkg::MODE_FUNC),
        .pin_inputs     (pin_inputs),
        .test_inputs    (test_vector),
        .core_inputs    (core_inputs),
        .pin_drivers_en (pin_drivers_en)
    );

endmodule : bsta_slave

// ---- testbench/bsta_slave_properties.sv ----
`timescale 1ns/1ps
module bsta_slave_props (
    input wire logic                        sys_clk,
    input wire logic                        rst,
    input wire logic                        bus_sel,
    input wire logic                        bus_write,
    input wire logic [31:0]                 slave_address_in,
    input wire logic [31:0]                 bus_wdata,
    input wire logic [31:0]                 bus_rdata,
    input wire logic                        bus_rvalid,
    input wire bsta_pkg::bsta_core_in_type  pin_inputs,
    input wire bsta_pkg::bsta_core_out_type core_outputs,
    input wire bsta_pkg::bsta_core_in_type  core_inputs,
    input wire logic                        pin_drivers_en,
    input wire logic [31:0]                 core_data_in,
    input wire logic [31:0]                 core_coproc_data_in,
    input wire logic                        core_step,
    input wire bsta_pkg::bsta_mode_type     test_mode
);
    logic rd_ok;
    logic mode_wr;
    assign rd_ok   = bus_sel && !bus_write && slave_address_in[1:0] == 2'h0;
    assign mode_wr = bus_sel && bus_write && slave_address_in[11:0] == 12'h000;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_read_answer; rd_ok |=> bus_rvalid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_no_answer; !rd_ok |=> !bus_rvalid; endproperty
    a_no_answer: assert property (p_no_answer) else $error("answer without read");
    property p_mode_switch;
        mode_wr && bus_wdata <= bsta_pkg::CODE_DCACHE |=> test_mode == 7'h01 << $past(bus_wdata[2:0]);
    endproperty
    a_mode_switch: assert property (p_mode_switch) else $error("mode not switched");
    property p_bad_code; mode_wr && bus_wdata > bsta_pkg::CODE_DCACHE |=> $stable(test_mode); endproperty
    a_bad_code: assert property (p_bad_code) else $error("undefined code changed mode");
    property p_isolate; test_mode == bsta_pkg::MODE_FUNC |=> !pin_drivers_en; endproperty
    a_isolate: assert property (p_isolate) else $error("drivers on in functional mode");
    property p_exit_drivers; mode_wr && bus_wdata == bsta_pkg::CODE_EXIT |=> ##1 pin_drivers_en; endproperty
    a_exit_drivers: assert property (p_exit_drivers) else $error("drivers off after exit");
    property p_follow_pins; test_mode == bsta_pkg::MODE_EXIT |=> core_inputs == $past(pin_inputs); endproperty
    a_follow_pins: assert property (p_follow_pins) else $error("core not on pins in exit");
    property p_step_cause; core_step |-> $past(bus_sel); endproperty
    a_step_cause: assert property (p_step_cause) else $error("step without access");
    property p_exit_reads;
        test_mode == bsta_pkg::MODE_EXIT && rd_ok && slave_address_in[11:2] != 10'h0 |=> bus_rdata == 32'h0;
    endproperty
    a_exit_reads: assert property (p_exit_reads) else $error("data visible outside test");
endmodule : bsta_slave_props

// ---- testbench/bsta_core_model.sv ----
`timescale 1ns/1ps
// stand-in core: outputs derived combinationally so reads see fresh values
module bsta_core_model (
    input  wire logic [31:0]                core_data_in,
    input  wire logic [31:0]                core_coproc_data_in,
    input  wire bsta_pkg::bsta_core_in_type core_inputs,
    output bsta_pkg::bsta_core_out_type     core_outputs
);
    assign core_outputs = {~core_data_in, core_coproc_data_in + 32'h1, core_inputs, core_inputs[21:0],
                           core_inputs[15:0], core_inputs[31:16], core_data_in ^ core_coproc_data_in};
endmodule : bsta_core_model

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic                        sys_clk, rst, bus_sel, bus_write, bus_rvalid, pin_drivers_en, core_step, stp, rv;
    logic [31:0]                 slave_address_in, bus_wdata, bus_rdata, core_data_in, core_coproc_data_in, rd;
    logic [31:0]                 exp_q [5];
    bsta_pkg::bsta_core_in_type  pin_inputs, core_inputs;
    bsta_pkg::bsta_core_out_type core_outputs;
    bsta_pkg::bsta_mode_type     test_mode;
    int                          err_count, num_checks;
    localparam logic [31:0] VEC = 32'ha5f3_c35a;
    localparam logic [31:0] VSTORED = 32'ha403_c35a;
    localparam logic [31:0] DATA_WORD = 32'h1234_5678;
    localparam logic [31:0] CPD = 32'h0bad_f00d;
    bsta_slave u_bsta_slave (.sys_clk(sys_clk), .rst(rst), .bus_sel(bus_sel), .bus_write(bus_write),
        .slave_address_in(slave_address_in), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .pin_inputs(pin_inputs), .core_outputs(core_outputs), .core_inputs(core_inputs),
        .pin_drivers_en(pin_drivers_en), .core_data_in(core_data_in), .core_coproc_data_in(core_coproc_data_in),
        .core_step(core_step), .test_mode(test_mode));
    bsta_core_model u_bsta_core_model (.core_data_in(core_data_in), .core_coproc_data_in(core_coproc_data_in),
        .core_inputs(core_inputs), .core_outputs(core_outputs));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task chk_data(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t data %h expected %h", $time, got, exp);
        end
    endtask : chk_data
    task chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag
    task chk_mode(input bsta_pkg::bsta_mode_type got, input bsta_pkg::bsta_mode_type exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t mode %b expected %b", $time, got, exp);
        end
    endtask : chk_mode
    // one-cycle strobe, released right after the edge that takes it
    task acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_sel <= 1'b1;
        bus_write <= w;
        slave_address_in <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_sel <= 1'b0;
    endtask : acc
    task rd_at(input logic [31:0] a);
        acc(1'b0, a, 32'h0);
        @(posedge sys_clk);
        rv = bus_rvalid;
        rd = bus_rdata;
        stp = core_step;
    endtask : rd_at
    task mode(input logic [31:0] code);
        acc(1'b1, 32'h0, code);
        @(posedge sys_clk);
    endtask : mode
    task results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (2000) @(posedge sys_clk);
        err_count++;
        results();
    end
    initial begin
        rst = 1'b1;
        bus_sel = 1'b0;
        bus_write = 1'b0;
        slave_address_in = 32'h0;
        bus_wdata = 32'h0;
        pin_inputs = bsta_pkg::bsta_core_in_type'(32'h0f0f_3c3c);
        err_count = 0;
        num_checks = 0;
        exp_q = '{CPD + 32'h1, VSTORED, {10'h0, VSTORED[21:0]}, {VSTORED[15:0], VSTORED[31:16]}, DATA_WORD ^ CPD};
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd_at(32'h0000_0ffc);
        chk_flag(rv, 1'b1);
        chk_data(rd, 32'h0);
        rd_at(32'h0000_0082);
        chk_flag(rv, 1'b0);
        chk_data(core_inputs, pin_inputs);
        mode(32'h7);
        chk_mode(test_mode, bsta_pkg::MODE_EXIT);
        for (int k = 6; k >= 1; k--) begin
            mode(32'(k));
            chk_mode(test_mode, bsta_pkg::bsta_mode_type'(7'h01 << k));
        end
        @(posedge sys_clk);
        chk_flag(pin_drivers_en, 1'b0);
        pin_inputs <= bsta_pkg::bsta_core_in_type'(32'hffff_ffff);
        acc(1'b1, 32'h0000_07fc, CPD);
        acc(1'b1, 32'h0000_07fc, VEC);
        acc(1'b1, 32'h0000_07fc, DATA_WORD);
        rd_at(32'h0000_07fc);
        chk_data(core_coproc_data_in, CPD);
        chk_data(core_inputs, VSTORED);
        chk_data(core_data_in, DATA_WORD);
        chk_data(rd, ~DATA_WORD);
        chk_flag(stp, 1'b1);
        for (int i = 0; i < 5; i++) begin
            rd_at(32'h0000_07fc);
            chk_data(rd, exp_q[i]);
            chk_flag(stp, 1'b0);
        end
        rd_at(32'h0000_0400);
        chk_data(rd, 32'h0);
        // a vector with no reads still gets its clock when the next one starts
        acc(1'b1, 32'h0000_0400, CPD);
        acc(1'b1, 32'h0000_0400, DATA_WORD);
        @(posedge sys_clk);
        chk_flag(core_step, 1'b1);
        chk_data(core_coproc_data_in, DATA_WORD);
        mode(32'h0);
        chk_mode(test_mode, bsta_pkg::MODE_EXIT);
        chk_flag(core_step, 1'b1);
        @(posedge sys_clk);
        @(posedge sys_clk);
        chk_flag(pin_drivers_en, 1'b1);
        chk_data(core_inputs, 32'hffff_ffff);
        results();
    end
endmodule : tb
bind bsta_slave bsta_slave_props u_bsta_slave_props (.sys_clk(sys_clk), .rst(rst), .bus_sel(bus_sel),
    .bus_write(bus_write), .slave_address_in(slave_address_in), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .pin_inputs(pin_inputs), .core_outputs(core_outputs), .core_inputs(core_inputs),
    .pin_drivers_en(pin_drivers_en), .core_data_in(core_data_in), .core_coproc_data_in(core_coproc_data_in),
    .core_step(core_step), .test_mode(test_mode));
